// *** verilog/hbp_pkg.sv ***
// constants, field layout and encodings of the h-bridge pwm configuration
package hbp_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int HBP_CH_N   = 4;         // channels
	localparam int HBP_PER_W  = 11;        // period and duty width
	localparam int HBP_ADDR_W = 8;         // axi byte address width
	localparam int HBP_DATA_W = 32;        // axi data width
	localparam int HBP_IDX_W  = 6;         // register index width
	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [5:0] HBP_IDX_CTL0 = 6'h00; // prescaler, dither, flag
	localparam logic [5:0] HBP_IDX_CTL1 = 6'h01; // freewheel side, irq enable
	localparam logic [5:0] HBP_IDX_PER  = 6'h02; // period length
	localparam logic [5:0] HBP_IDX_CHC  = 6'h10; // channel control 0, 1..3
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int HBP_CTL0_PRE_LSB  = 5;  // tick prescaler, two bits
	localparam int HBP_CTL0_JITTER_SPREAD_ENABLE_BIT = 2;  // jitter spread enable
	localparam int HBP_CTL0_FLAG_BIT = 0;  // overflow flag, write one clears
	localparam int HBP_CTL1_FW_BIT   = 7;  // freewheel side select
	localparam int HBP_CTL1_IE_BIT   = 0;  // overflow irq enable
	localparam int HBP_CHC_MODE_LSB  = 6;  // bridge output mode, two bits
	localparam int HBP_CHC_ALIGN_LSB = 4;  // alignment mode, two bits
	localparam int HBP_CHC_DLY_LSB   = 0;  // channel delay, two bits
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  HBP_RST_BYTE = 8'h00;  // all 8-bit registers
	localparam logic [15:0] HBP_RST_PER  = 16'h0000; // period length
	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		HBP_HALF_MINUS = 2'b00,            // pwm on minus pin
		HBP_HALF_PLUS  = 2'b01,            // pwm on plus pin
		HBP_FULL       = 2'b10,            // full bridge
		HBP_DUAL_FULL  = 2'b11             // dual full bridge
	} hbp_mode_t;
	typedef enum logic [1:0] {
		HBP_AL_OFF    = 2'b00,             // channel disabled
		HBP_AL_LEFT   = 2'b01,             // left aligned
		HBP_AL_RIGHT  = 2'b10,             // right aligned
		HBP_AL_CENTER = 2'b11              // center aligned
	} hbp_align_t;
	localparam logic [1:0] HBP_RESP_OKAY   = 2'b00; // axi okay
	localparam logic [1:0] HBP_RESP_SLVERR = 2'b10; // unmapped address
endpackage

// *** verilog/hbp_ch_if.sv ***
// per-channel link between the timing engine and the pin mapper
`timescale 1ns/1ns
`default_nettype none
interface hbp_ch_if;
	import hbp_pkg::*;
	logic      level;      // delayed pwm active phase
	logic      enabled;    // working alignment on and period non-zero
	hbp_mode_t mode;       // working bridge output mode
	logic      freewheel;  // freewheel side select
	logic      sign;       // duty sign bit
	logic      plus;       // plus pin value
	logic      minus;      // minus pin value
	logic      plus_oe;    // plus pin driven
	logic      minus_oe;   // minus pin driven
	modport src (output level, enabled, mode, freewheel, sign,
		input plus, minus, plus_oe, minus_oe);
	modport map (input level, enabled, mode, freewheel, sign,
		output plus, minus, plus_oe, minus_oe);
endinterface
`default_nettype wire

// *** verilog/hbp_pin_map.sv ***
// maps one channel's pwm phase onto its bridge pin pair
`timescale 1ns/1ns
`default_nettype none
module hbp_pin_map (
	hbp_ch_if.map p        // channel link
);
	import hbp_pkg::*;
	logic pwm_val;         // pin value in the pwm phase
	logic static_val;      // value of the static pin
	logic swap;            // pwm on minus pin in full modes

	// ------------------------------------------------------------
	// pin pattern
	// ------------------------------------------------------------
	// released pins keep value low so nothing floats into the registers
	always_comb
	begin
		pwm_val    = p.freewheel ? p.level : ~p.level;
		static_val = ~p.freewheel;
		swap       = p.sign ^ p.freewheel;
		p.plus     = 1'b0;
		p.minus    = 1'b0;
		p.plus_oe  = 1'b0;
		p.minus_oe = 1'b0;
		if (p.enabled)
		begin
			case (p.mode)
				// half modes ignore freewheel, always active low
				HBP_HALF_MINUS:
				begin
					p.minus    = ~p.level;
					p.minus_oe = 1'b1;
				end
				HBP_HALF_PLUS:
				begin
					p.plus    = ~p.level;
					p.plus_oe = 1'b1;
				end
				// full and dual full: freewheel steers both pins
				default:
				begin
					p.plus_oe  = 1'b1;
					p.minus_oe = 1'b1;
					p.minus    = swap ? pwm_val : static_val;
					p.plus     = swap ? static_val : pwm_val;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// *** verilog/hbp_top.sv ***
// h-bridge pwm generator: register file, period timer and channel outputs
`timescale 1ns/1ns
`default_nettype none
module hbp_top
	import hbp_pkg::*;
(
	input  wire logic                    aclk,          // bus clock
	input  wire logic                    aresetn,       // sync reset, low
	input  wire logic                    ce,            // clock enable
	input  wire logic [HBP_ADDR_W-1:0]   s_axi_awaddr,  // write address
	input  wire logic                    s_axi_awvalid, // write addr valid
	output logic                         s_axi_awready, // write addr ready
	input  wire logic [HBP_DATA_W-1:0]   s_axi_wdata,   // write data
	input  wire logic [3:0]              s_axi_wstrb,   // byte enables
	input  wire logic                    s_axi_wvalid,  // write data valid
	output logic                         s_axi_wready,  // write data ready
	output logic [1:0]                   s_axi_bresp,   // write response
	output logic                         s_axi_bvalid,  // response valid
	input  wire logic                    s_axi_bready,  // response ready
	input  wire logic [HBP_ADDR_W-1:0]   s_axi_araddr,  // read address
	input  wire logic                    s_axi_arvalid, // read addr valid
	output logic                         s_axi_arready, // read addr ready
	output logic [HBP_DATA_W-1:0]        s_axi_rdata,   // read data
	output logic [1:0]                   s_axi_rresp,   // read response
	output logic                         s_axi_rvalid,  // read data valid
	input  wire logic                    s_axi_rready,  // read data ready
	input  wire logic [3:0][HBP_PER_W-1:0] duty_count,  // duty per channel
	input  wire logic [3:0]              duty_sign,     // sign per channel
	output logic [3:0]                   plus_pin,      // plus pin values
	output logic [3:0]                   plus_pin_oe,   // plus pin drive
	output logic [3:0]                   minus_pin,     // minus pin values
	output logic [3:0]                   minus_pin_oe,  // minus pin drive
	output logic                         irq            // overflow irq
);
	import hbp_pkg::*;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// channel control hit for an index
	function automatic logic chc_hit(input logic [5:0] idx);
		chc_hit = (idx[5:2] == HBP_IDX_CHC[5:2]);
	endfunction
	// divider terminal count for a prescaler code
	function automatic logic [2:0] div_lim(input logic [1:0] code);
		div_lim = 3'((4'h1 << code) - 4'h1);
	endfunction
	// pwm active phase for one channel
	function automatic logic pwm_on(input hbp_align_t al,
		input logic [10:0] c, input logic [10:0] cycle_length,
		input logic [10:0] d);
		logic [12:0] c2;  // 13 bits: twice the count must not wrap
		c2 = {1'b0, c, 1'b0};
		case (al)
			HBP_AL_LEFT:   pwm_on = (c < d);
			HBP_AL_RIGHT:  pwm_on = ({1'b0, c} + {1'b0, d}) >= {1'b0, cycle_length};
			HBP_AL_CENTER: pwm_on = (c2 + {2'b00, d} >= {2'b00, cycle_length}) &&
				(c2 < {2'b00, cycle_length} + {2'b00, d});
			default:       pwm_on = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// register and bus state
	// ------------------------------------------------------------
	logic [1:0]  pre_q, pre_d;             // tick prescaler
	logic        jitter_spread_enable_q, jitter_spread_enable_d;           // jitter spread enable
	logic        flag_q, flag_d;           // overflow flag
	logic        fw_q, fw_d;               // freewheel side select
	logic        ie_q, ie_d;               // overflow irq enable
	logic [10:0] per_q, per_d;             // period length as written
	logic [3:0][7:0] chc_q, chc_d;         // channel control as written
	logic        awf_q, awf_d;             // write address held
	logic [5:0]  awi_q, awi_d;             // held write index
	logic        wf_q, wf_d;               // write data held
	logic [31:0] wd_q, wd_d;               // held write data
	logic [3:0]  ws_q, ws_d;               // held byte enables
	logic        bv_q, bv_d;               // write response valid
	logic [1:0]  br_q, br_d;               // write response code
	logic        rv_q, rv_d;               // read data valid
	logic [31:0] rd_q, rd_d;               // read data
	logic [1:0]  rr_q, rr_d;               // read response code
	logic        do_wr;                    // write performed this cycle
	logic [5:0]  ari;                      // read index
	logic        ovf;                      // counter overflow event
	logic [10:0] eff_per;                  // period seen by the counter

	assign s_axi_awready = ce & ~awf_q;
	assign s_axi_wready  = ce & ~wf_q;
	assign s_axi_arready = ce & ~rv_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = br_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rdata   = rd_q;
	assign s_axi_rresp   = rr_q;
	assign irq           = flag_q & ie_q;
	assign do_wr         = awf_q & wf_q & ~bv_q;
	assign ari           = s_axi_araddr[7:2];
	// lsb dropped under dither; 0x0001 thus collapses to zero
	assign eff_per = jitter_spread_enable_q ? {per_q[10:1], 1'b0} : per_q;

	// ------------------------------------------------------------
	// bus slave and register next state
	// ------------------------------------------------------------
	// address and data are held apart so either may come first
	always_comb
	begin
		pre_d = pre_q;  jitter_spread_enable_d = jitter_spread_enable_q;  fw_d = fw_q;  ie_d = ie_q;
		per_d = per_q;  chc_d = chc_q;
		awf_d = awf_q;  awi_d = awi_q;  wf_d = wf_q;
		wd_d = wd_q;  ws_d = ws_q;  bv_d = bv_q;  br_d = br_q;
		rv_d = rv_q;  rd_d = rd_q;  rr_d = rr_q;
		// set wins over a clear in the same cycle
		flag_d = flag_q | ovf;
		if (s_axi_awvalid && s_axi_awready)
		begin
			awf_d = 1'b1;
			awi_d = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			wf_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			bv_d = 1'b0;
		if (do_wr)
		begin
			awf_d = 1'b0;
			wf_d  = 1'b0;
			bv_d  = 1'b1;
			br_d  = HBP_RESP_OKAY;
			if (awi_q == HBP_IDX_CTL0 && ws_q[0])
			begin
				pre_d  = wd_q[HBP_CTL0_PRE_LSB +: 2];
				jitter_spread_enable_d = wd_q[HBP_CTL0_JITTER_SPREAD_ENABLE_BIT];
				flag_d = ovf | (flag_q & ~wd_q[HBP_CTL0_FLAG_BIT]);
			end
			else if (awi_q == HBP_IDX_CTL1 && ws_q[0])
			begin
				fw_d = wd_q[HBP_CTL1_FW_BIT];
				ie_d = wd_q[HBP_CTL1_IE_BIT];
			end
			else if (awi_q == HBP_IDX_PER)
			begin
				if (ws_q[0])
					per_d[7:0] = wd_q[7:0];
				if (ws_q[1])
					per_d[10:8] = wd_q[10:8];
			end
			else if (chc_hit(awi_q))
			begin
				// bits 3:2 are unimplemented and stay zero
				if (ws_q[0])
					chc_d[awi_q[1:0]] = {wd_q[7:4], 2'b00,
						wd_q[1:0]};
			end
			else if (awi_q != HBP_IDX_CTL0 && awi_q != HBP_IDX_CTL1)
				br_d = HBP_RESP_SLVERR;
		end
		if (s_axi_rvalid && s_axi_rready)
			rv_d = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rv_d = 1'b1;
			rr_d = HBP_RESP_OKAY;
			rd_d = 32'h0000_0000;
			if (ari == HBP_IDX_CTL0)
				rd_d[7:0] = {1'b0, pre_q, 2'b00, jitter_spread_enable_q, 1'b0, flag_q};
			else if (ari == HBP_IDX_CTL1)
				rd_d[7:0] = {fw_q, 6'h00, ie_q};
			else if (ari == HBP_IDX_PER)
				rd_d[10:0] = eff_per;
			else if (chc_hit(ari))
				rd_d[7:0] = chc_q[ari[1:0]];
			else
				rr_d = HBP_RESP_SLVERR;
		end
	end

	// register the bus and register-file state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pre_q <= 2'h0;  jitter_spread_enable_q <= 1'b0;  flag_q <= 1'b0;
			fw_q <= 1'b0;  ie_q <= 1'b0;
			per_q <= HBP_RST_PER[10:0];
			chc_q <= {4{HBP_RST_BYTE}};
			awf_q <= 1'b0;  awi_q <= 6'h00;  wf_q <= 1'b0;
			wd_q <= 32'h0000_0000;  ws_q <= 4'h0;
			bv_q <= 1'b0;  br_q <= 2'h0;
			rv_q <= 1'b0;  rd_q <= 32'h0000_0000;  rr_q <= 2'h0;
		end
		else if (ce)
		begin
			pre_q <= pre_d;  jitter_spread_enable_q <= jitter_spread_enable_d;  flag_q <= flag_d;
			fw_q <= fw_d;  ie_q <= ie_d;  per_q <= per_d;  chc_q <= chc_d;
			awf_q <= awf_d;  awi_q <= awi_d;  wf_q <= wf_d;
			wd_q <= wd_d;  ws_q <= ws_d;  bv_q <= bv_d;  br_q <= br_d;
			rv_q <= rv_d;  rd_q <= rd_d;  rr_q <= rr_d;
		end
	end

	// ------------------------------------------------------------
	// timer, working copies and pins
	// ------------------------------------------------------------
	logic [2:0]  div_q, div_d;             // prescaler divider
	logic [10:0] cnt_q, cnt_d;             // period counter
	logic [10:0] perw_q, perw_d;           // working period
	logic [1:0]  prew_q, prew_d;           // working prescaler
	hbp_mode_t  [3:0] modew_q, modew_d;    // working output modes
	hbp_align_t [3:0] alw_q, alw_d;        // working alignments
	logic [3:0][2:0] dly_q, dly_d;         // delay taps per channel
	logic [3:0]  pp_d, ppo_d, mp_d, mpo_d; // next pin values
	logic        active;                   // working period non-zero
	logic        tick;                     // counter tick
	logic        any_en;                   // some working channel on
	logic [3:0]  lvl;                      // undelayed pwm phase

	assign active = (perw_q != 11'h000);
	assign tick   = active && (div_q == div_lim(prew_q));
	assign ovf    = tick && (cnt_q == perw_q - 11'h001);
	assign any_en = (alw_q != {4{HBP_AL_OFF}});

	genvar g;
	generate
		for (g = 0; g < HBP_CH_N; g++)
		begin : g_ch
			hbp_ch_if ch ();
			assign lvl[g] = pwm_on(alw_q[g], cnt_q, perw_q, duty_count[g]);
			// tap zero is the live phase, later taps lag one tick each
			assign ch.level = (chc_q[g][1:0] == 2'b00) ? lvl[g] :
				dly_q[g][chc_q[g][1:0] - 2'b01];
			// enable is not delayed, so release is immediate
			assign ch.enabled   = active && (alw_q[g] != HBP_AL_OFF);
			assign ch.mode      = modew_q[g];
			assign ch.freewheel = fw_q;
			assign ch.sign      = duty_sign[g];
			assign pp_d[g]  = ch.plus;
			assign ppo_d[g] = ch.plus_oe;
			assign mp_d[g]  = ch.minus;
			assign mpo_d[g] = ch.minus_oe;
			hbp_pin_map u_map (
				.p (ch)
			);
			// half mode pwm pin is the inverse of the phase
			chk_half_low: assert property (@(posedge aclk)
				disable iff (!aresetn)
				(ch.enabled && ch.mode == HBP_HALF_MINUS) |->
				(ch.minus == !ch.level && !ch.plus_oe))
				else $error("half mode pin not active low");
			chk_fw_static: assert property (@(posedge aclk)
				disable iff (!aresetn)
				(ch.enabled && ch.mode[1] && ch.freewheel) |->
				(ch.sign ? ch.minus == 1'b0 : ch.plus == 1'b0))
				else $error("static pin not low under freewheel");
		end
	endgenerate

	// counter, divider, buffered settings and delay taps
	always_comb
	begin
		div_d = div_q;  cnt_d = cnt_q;  perw_d = perw_q;  prew_d = prew_q;
		modew_d = modew_q;  alw_d = alw_q;  dly_d = dly_q;
		if (!active)
		begin
			// idle: take the new period and prescaler at once
			perw_d = eff_per;
			prew_d = pre_q;
			div_d  = 3'h0;
			cnt_d  = 11'h000;
		end
		else
		begin
			div_d = tick ? 3'h0 : div_q + 3'h1;
			if (tick)
				cnt_d = ovf ? 11'h000 : cnt_q + 11'h001;
			if (ovf)
			begin
				perw_d = eff_per;
				prew_d = pre_q;
			end
		end
		if (!active || !any_en || ovf)
		begin
			for (int i = 0; i < HBP_CH_N; i++)
			begin
				modew_d[i] = hbp_mode_t'(chc_q[i][HBP_CHC_MODE_LSB +: 2]);
				alw_d[i] = hbp_align_t'(chc_q[i][HBP_CHC_ALIGN_LSB +: 2]);
			end
		end
		if (tick)
			for (int i = 0; i < HBP_CH_N; i++)
				dly_d[i] = {dly_q[i][1:0], lvl[i]};
	end

	// register timer state and pins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_q <= 3'h0;  cnt_q <= 11'h000;
			perw_q <= 11'h000;  prew_q <= 2'h0;
			modew_q <= {4{HBP_HALF_MINUS}};  alw_q <= {4{HBP_AL_OFF}};
			dly_q <= '0;
			plus_pin <= 4'h0;  plus_pin_oe <= 4'h0;
			minus_pin <= 4'h0;  minus_pin_oe <= 4'h0;
		end
		else if (ce)
		begin
			div_q <= div_d;  cnt_q <= cnt_d;
			perw_q <= perw_d;  prew_q <= prew_d;
			modew_q <= modew_d;  alw_q <= alw_d;  dly_q <= dly_d;
			plus_pin <= pp_d;  plus_pin_oe <= ppo_d;
			minus_pin <= mp_d;  minus_pin_oe <= mpo_d;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_ovf_seen;
		ce && ovf;
	endsequence
	sequence s_flag_up;
		##1 flag_q;
	endsequence
	chk_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ovf_seen |-> s_flag_up)
		else $error("overflow did not set flag");
	chk_flag_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(flag_q && !(do_wr && awi_q == HBP_IDX_CTL0)) |=> flag_q)
		else $error("flag dropped without a clear");
	chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_ovf_seen ##0 ie_q && !(ce && do_wr)) |=> irq)
		else $error("enabled overflow raised no irq");
	chk_irq_off: assert property (@(posedge aclk) disable iff (!aresetn)
		!ie_q |-> !irq)
		else $error("irq while disabled");
	chk_period_len: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && active) |-> (cnt_q < perw_q))
		else $error("counter ran past the period");
	chk_jitter_spread_enable_lsb: assert property (@(posedge aclk) disable iff (!aresetn)
		jitter_spread_enable_q |-> !eff_per[0])
		else $error("dither left period lsb");
	chk_zero_rel: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && !active) |=> (plus_pin_oe == 4'h0 &&
		minus_pin_oe == 4'h0))
		else $error("pins driven with zero period");
	chk_buf_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && active && any_en && !ovf) |=> $stable(alw_q))
		else $error("alignment changed outside overflow");
	chk_tick_div: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && tick && prew_q == 2'h3 && prew_d == 2'h3) |=>
		!tick [*7])
		else $error("divide by eight ticks too soon");
endmodule
`default_nettype wire

// *** tb/hbp_load.sv ***
// far-side load model of the four bridge pin pairs
`timescale 1ns/1ns
`default_nettype none
module hbp_load (
	input  wire logic       clk,  // bus clock
	input  wire logic [3:0] p,    // plus pin values
	input  wire logic [3:0] p_oe, // plus pin drive
	input  wire logic [3:0] m,    // minus pin values
	input  wire logic [3:0] m_oe, // minus pin drive
	output logic [3:0]      p_w,  // plus wire level
	output logic [3:0]      m_w   // minus wire level
);
	logic [3:0] p_q; // last plus wire level
	logic [3:0] m_q; // last minus wire level
	// a released wire has no pull, so it toggles each cycle
	always_ff @(posedge clk)
	begin
		p_q <= p_w;
		m_q <= m_w;
	end
	assign p_w = (p & p_oe) | (~p_q & ~p_oe);
	assign m_w = (m & m_oe) | (~m_q & ~m_oe);
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the h-bridge pwm generator
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import hbp_pkg::*;
	logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid;
	logic bready, arvalid, arready, rvalid, rready, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, v;
	logic [1:0] bresp, rresp, rr, wbr;
	logic [3:0][10:0] duty;
	logic [3:0] sgn, pp, pe, mp, me, pw, mw;
	int mismatches, cmp_count, k;
	integer seed;
	initial
	begin
		aclk = 0;
		forever #4 aclk = ~aclk;
	end
	hbp_top hbp_top_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .duty_count(duty),
		.duty_sign(sgn), .plus_pin(pp), .plus_pin_oe(pe), .minus_pin(mp),
		.minus_pin_oe(me), .irq(irq));
	hbp_load hbp_load_i (.clk(aclk), .p(pp), .p_oe(pe), .m(mp),
		.m_oe(me), .p_w(pw), .m_w(mw));
	// compare and count
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
	begin
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	end
	endtask
	// axi write: address and data offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		bit ta, tw;
	begin
		ta = 0;
		tw = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		while (!(ta && tw))
		begin
			@(posedge aclk);
			if (!ta && awready)
			begin
				ta = 1;
				awvalid <= 0;
			end
			if (!tw && wready)
			begin
				tw = 1;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		wbr = bresp;
	end
	endtask
	// axi read; bready and rready are simply held high
	task rdr(input logic [7:0] a);
	begin
		araddr <= a;
		arvalid <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		rd = rdata;
		rr = rresp;
	end
	endtask
	task all_ch(input logic [7:0] c);
		for (int i = 0; i < 4; i++) wr(8'h40 + 8'(i * 4), {24'h0, c});
	endtask
	// full-bridge pin level at full duty: pwm side shows the active level
	function automatic logic [3:0] lvl(input logic f, s, mn);
		return {4{(s ^ f ^ mn) ? ~f : f}};
	endfunction
	task complete_run;
	begin
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		repeat (30000) @(posedge aclk);
		mismatches++;
		complete_run;
	end
	initial
	begin
		seed = 32'h7a99;
		{mismatches, cmp_count, awaddr, araddr, wdata, duty, sgn} = '0;
		{aresetn, awvalid, wvalid, arvalid} = 4'h0;
		{ce, bready, rready} = 3'h7;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		for (k = 0; k < 4; k++)
		begin
			rdr(8'(k == 3 ? 'h40 : k * 4));
			chk("reset value", 0, rd);
		end
		rdr(8'h0C);
		chk("unmapped resp", 32'(HBP_RESP_SLVERR), 32'(rr));
		wr(8'h0C, 32'h1);
		chk("unmapped bresp", 32'(HBP_RESP_SLVERR), 32'(wbr));
		// period still zero: copies load at once, pins stay released
		for (k = 0; k < 4; k++)
		begin
			v = $random(seed);
			wr(8'h40 + 8'(k * 4), {24'h0, v[7:0]});
			rdr(8'h40 + 8'(k * 4));
			chk("channel reg", {24'h0, v[7:0] & 8'hF3}, rd);
		end
		chk("oe zero period", 0, {pe, me});
		wr(8'h04, 32'h1);
		wr(8'h08, 32'h10);
		for (k = 0; k < 4; k++)
		begin
			duty <= 44'({$random(seed), $random(seed)});
			sgn <= 4'($random(seed));
			all_ch({k[1:0], 6'h10});
			repeat (40) @(posedge aclk);
			chk("plus oe", k == 0 ? 0 : 4'hF, pe);
			chk("minus oe", k == 1 ? 0 : 4'hF, me);
		end
		chk("irq on", 1, irq);
		rdr(8'h00);
		chk("flag set", 1, rd[0]);
		duty <= {4{11'h010}};
		for (k = 0; k < 4; k++)
		begin
			// freewheel changes only with every channel in half mode
			all_ch(8'h10);
			repeat (40) @(posedge aclk);
			chk("half minus", 0, mw);
			wr(8'h04, {24'h0, k[1], 7'h1});
			sgn <= {4{k[0]}};
			// full duty is active in every alignment and after any delay
			all_ch({2'b10, 2'(k % 3 + 1), 2'b00, k[1:0]});
			repeat (40) @(posedge aclk);
			chk("full plus", lvl(k[1], k[0], 0), pw);
			chk("full minus", lvl(k[1], k[0], 1), mw);
		end
		wr(8'h00, 32'h4);
		wr(8'h08, 32'h23);
		rdr(8'h08);
		chk("dither period", 32'h22, rd);
		duty <= '0;
		repeat (40) @(posedge aclk);
		wr(8'h08, 32'h1);
		repeat (40) @(posedge aclk);
		chk("oe period one", 0, {pe, me});
		wr(8'h04, 32'h0);
		chk("irq off", 0, irq);
		// keep dither on while clearing, so the period stays at zero
		wr(8'h00, 32'h5);
		rdr(8'h00);
		chk("flag clear", 0, rd[0]);
		complete_run;
	end
endmodule
`default_nettype wire
